// ==== abbe_pkg.sv ====
// Shared constants and types for the AND, branch and bit-clear execution block
package abbe_pkg;

  localparam int ADDR_W = 8;
  localparam int MEM_AW = 12;
  localparam int MEM_DEPTH = 4096;
  localparam int PC_W = 16;

  // Register byte offsets on the AXI4-Lite slave
  localparam logic [ADDR_W-1:0] REG_INSTR = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_ACC = 8'h08;
  localparam logic [ADDR_W-1:0] REG_FLAGS = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_PC = 8'h10;
  localparam logic [ADDR_W-1:0] REG_BANK = 8'h14;
  localparam logic [ADDR_W-1:0] REG_MEMADDR = 8'h18;
  localparam logic [ADDR_W-1:0] REG_MEMDATA = 8'h1c;
  localparam logic [ADDR_W-1:0] REG_LASTOP = 8'h20;
  localparam logic [ADDR_W-1:0] REG_RETIRED = 8'h24;

  // Flag bit positions
  localparam int FLG_C = 0;
  localparam int FLG_DC = 1;
  localparam int FLG_Z = 2;
  localparam int FLG_OV = 3;
  localparam int FLG_N = 4;

  // Status bit positions
  localparam int STAT_BUSY = 0;
  localparam int STAT_TAKEN = 1;
  localparam int STAT_ILLEGAL = 2;
  localparam int STAT_CYC = 4;

  // Values after reset
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [4:0] FLAGS_RST = 5'h00;
  localparam logic [PC_W-1:0] PC_RST = 16'h0000;
  localparam logic [3:0] BANK_RST = 4'h0;
  localparam logic [15:0] INSTR_RST = 16'h0000;

  // Opcode patterns
  localparam logic [7:0] OPC_ANDLIT = 8'h0b;
  localparam logic [5:0] OPC_ANDREG = 6'h05;
  localparam logic [5:0] OPC_ADDC = 6'h08;
  localparam logic [3:0] OPC_BCLR = 4'h9;
  localparam logic [7:0] OPC_BC = 8'he2;
  localparam logic [7:0] OPC_BN = 8'he6;

  // Fixed access bank layout
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;
  localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hf;

  // Timing
  localparam logic [PC_W-1:0] PC_STEP = 16'h0002;
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_AND = 3'b001,
    OP_ADDC = 3'b010,
    OP_BCLR = 3'b011,
    OP_BRANCH = 3'b100
  } abbe_op_t;

  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b10,
    PH_Q4 = 2'b11
  } abbe_phase_t;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_EXEC = 2'b01,
    SEQ_NOP = 2'b10
  } abbe_seq_t;

endpackage : abbe_pkg

// ==== abbe_alu.sv ====
// Result and flag logic for AND, add-with-carry and bit clear
`timescale 1ns/10ps
`default_nettype none

module abbe_alu
  import abbe_pkg::*;
(
  input wire abbe_op_t op,
  input wire logic [7:0] accIn,
  input wire logic [7:0] operand,
  input wire logic [2:0] bitSel,
  input wire logic [4:0] flagsIn,
  output logic [7:0] result,
  output logic [4:0] flagsOut
);

  logic [8:0] sum;
  logic [4:0] lowSum;
  logic [4:0] mask;
  logic [4:0] calc;

  always_comb
  begin
    sum = {1'b0, accIn} + {1'b0, operand} + {8'h00, flagsIn[FLG_C]};
    lowSum = {1'b0, accIn[3:0]} + {1'b0, operand[3:0]} + {4'h0, flagsIn[FLG_C]};
    result = accIn;
    mask = 5'h00;
    unique case (op)
      OP_AND:
      begin
        result = accIn & operand; // RL1 RL3
        mask = 5'h00;
        mask[FLG_N] = 1'b1; // RL2
        mask[FLG_Z] = 1'b1;
      end
      OP_ADDC:
      begin
        result = sum[7:0]; // RL12
        mask = 5'h1f;
      end
      OP_BCLR:
      begin
        result = operand & ~(8'h01 << bitSel); // RL6
        mask = 5'h00;
      end
      default:
      begin
        result = accIn;
        mask = 5'h00;
      end
    endcase
    calc = flagsIn;
    calc[FLG_N] = result[7]; // RL14
    calc[FLG_Z] = (result == 8'h00); // RL14
    calc[FLG_C] = sum[8];
    calc[FLG_DC] = lowSum[4];
    calc[FLG_OV] = (accIn[7] == operand[7]) && (sum[7] != accIn[7]);
    flagsOut = (flagsIn & ~mask) | (calc & mask);
  end

endmodule : abbe_alu

`default_nettype wire

// ==== abbe_axil_slave.sv ====
// AXI4-Lite slave front end: one write and one read in flight
`timescale 1ns/10ps
`default_nettype none

module abbe_axil_slave
  import abbe_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic wrEn,
  output logic [ADDR_W-1:0] wrAddr,
  output logic [31:0] wrData,
  output logic [3:0] wrStrb,
  input wire logic wrHit,
  output logic rdEn,
  output logic [ADDR_W-1:0] rdAddr,
  input wire logic [31:0] rdVal,
  input wire logic rdHit
);

  logic awHeld;
  logic wHeld;

  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready = !wHeld && !s_axi_bvalid;
  assign wrEn = awHeld && wHeld && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign rdEn = s_axi_arvalid && s_axi_arready;
  assign rdAddr = s_axi_araddr;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      wrAddr <= '0;
      wrData <= 32'h0;
      wrStrb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHeld <= 1'b1;
        wrAddr <= s_axi_awaddr;
      end
      else if (wrEn)
        awHeld <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHeld <= 1'b1;
        wrData <= s_axi_wdata;
        wrStrb <= s_axi_wstrb;
      end
      else if (wrEn)
        wHeld <= 1'b0;
      if (wrEn)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrHit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (rdEn)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdHit ? rdVal : 32'h0;
      s_axi_rresp <= rdHit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule : abbe_axil_slave

`default_nettype wire

// ==== abbe_core.sv ====
// Decode and four-phase execution of AND, add-with-carry, bit clear and branches
//
// The address map and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

// What this block does
// RL1 - Literal AND into accumulator, opcode 0x0B
// RL2 - Register AND decode: dest, bank, address
// RL3 - Register AND reads memory, ANDs accumulator
// RL4 - Dest bit 0 accumulator, 1 register
// RL5 - Bank bit 0 access bank, 1 bank register
// RL6 - Bit clear one register bit, flags untouched
// RL7 - Branch on carry set, opcode 0xE2
// RL8 - Branch on negative set, flags untouched
// RL9 - Offset is signed eight-bit word count
// RL10 - Taken target is address plus 2 plus 2n
// RL11 - Branch one cycle, two when taken
// RL12 - Add with carry, all five flags
// RL13 - Decode, read, process, write per phase
// RL14 - AND sets negative and zero flags
module abbe_core
  import abbe_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic busy,
  output logic retire
);

  function automatic logic [15:0] laneMerge(
    input logic [15:0] oldVal,
    input logic [31:0] data,
    input logic [3:0] strb
  );
    laneMerge = {strb[1] ? data[15:8] : oldVal[15:8], strb[0] ? data[7:0] : oldVal[7:0]};
  endfunction : laneMerge

  // Bus side
  logic wrEn;
  logic [ADDR_W-1:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0] wrStrb;
  logic wrHit;
  logic rdEn;
  logic [ADDR_W-1:0] rdAddr;
  logic [31:0] rdVal;
  logic rdHit;

  // Architectural state
  logic [15:0] instr;
  logic [7:0] acc;
  logic [4:0] flags;
  logic [PC_W-1:0] pc;
  logic [3:0] bank;
  logic [MEM_AW-1:0] memAddr;
  logic [7:0] mem [0:MEM_DEPTH-1];

  // Sequencer and pipeline state
  abbe_seq_t state;
  abbe_seq_t next_state;
  abbe_phase_t phase;
  abbe_phase_t next_phase;
  abbe_op_t opKind;
  logic toReg;
  logic [MEM_AW-1:0] dataAddr;
  logic [2:0] bitSel;
  logic [7:0] operand;
  logic [7:0] aluRes;
  logic [4:0] aluFlags;
  logic brTaken;
  logic illegal;
  logic lastTaken;
  logic [1:0] lastCycles;
  logic [15:0] retiredCount;
  logic [7:0] aluResult;
  logic [4:0] aluFlagsOut;
  logic [31:0] statusWord;

  abbe_axil_slave u_slave (
    .clk(clk),
    .rst_n(rst_n),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .wrEn(wrEn),
    .wrAddr(wrAddr),
    .wrData(wrData),
    .wrStrb(wrStrb),
    .wrHit(wrHit),
    .rdEn(rdEn),
    .rdAddr(rdAddr),
    .rdVal(rdVal),
    .rdHit(rdHit)
  );

  abbe_alu u_alu (
    .op(opKind),
    .accIn(acc),
    .operand(operand),
    .bitSel(bitSel),
    .flagsIn(flags),
    .result(aluResult),
    .flagsOut(aluFlagsOut)
  );

  // Opcode decode
  wire isAndLit = (instr[15:8] == OPC_ANDLIT); // RL1
  wire isAndReg = (instr[15:10] == OPC_ANDREG); // RL2
  wire isAddc = (instr[15:10] == OPC_ADDC); // RL12
  wire isBclr = (instr[15:12] == OPC_BCLR); // RL6
  wire isBc = (instr[15:8] == OPC_BC); // RL7
  wire isBn = (instr[15:8] == OPC_BN); // RL8
  wire isBranch = isBc || isBn;
  wire destSel = instr[9]; // RL2
  wire accessSel = instr[8]; // RL2
  wire [7:0] fileAddr = instr[7:0];
  wire [2:0] bitField = instr[11:9]; // RL6

  wire abbe_op_t decOp = (isAndLit || isAndReg) ? OP_AND :
                         isAddc ? OP_ADDC :
                         isBclr ? OP_BCLR :
                         isBranch ? OP_BRANCH : OP_NONE;

  // Literal forms take the low byte directly instead of a memory read
  wire useLiteral = isAndLit || isBranch;

  // Access bank splits into the low part of bank 0 and the high part of the top bank
  wire [MEM_AW-1:0] accessAddr = (fileAddr < ACCESS_SPLIT) ? {ACCESS_LO_BANK, fileAddr} :
                                 {ACCESS_HI_BANK, fileAddr};
  wire [MEM_AW-1:0] effAddr = accessSel ? {bank, fileAddr} : accessAddr; // RL5

  // Branch target in bytes; offset counts instruction words
  wire [PC_W-1:0] offsetBytes = {{(PC_W-9){instr[7]}}, instr[7:0], 1'b0}; // RL9
  wire [PC_W-1:0] seqPc = pc + PC_STEP;
  wire [PC_W-1:0] branchPc = seqPc + offsetBytes; // RL10
  wire condMet = (isBc && flags[FLG_C]) || (isBn && flags[FLG_N]); // RL7 RL8

  // Phase strobes
  wire inExec = (state == SEQ_EXEC);
  wire inQ1 = inExec && (phase == PH_Q1);
  wire inQ2 = inExec && (phase == PH_Q2);
  wire inQ3 = inExec && (phase == PH_Q3);
  wire inQ4 = inExec && (phase == PH_Q4);
  wire nopEnd = (state == SEQ_NOP) && (phase == PH_Q4);
  wire writesMem = toReg && ((opKind == OP_AND) || (opKind == OP_ADDC) || (opKind == OP_BCLR));
  wire writesAcc = !toReg && ((opKind == OP_AND) || (opKind == OP_ADDC));
  wire coreMemWe = inQ4 && writesMem;

  // Register decode for the slave
  wire [ADDR_W-1:0] wrWord = {wrAddr[ADDR_W-1:2], 2'b00};
  wire [ADDR_W-1:0] rdWord = {rdAddr[ADDR_W-1:2], 2'b00};
  wire wrInstr = (wrWord == REG_INSTR);
  wire wrAcc = (wrWord == REG_ACC);
  wire wrFlags = (wrWord == REG_FLAGS);
  wire wrPc = (wrWord == REG_PC);
  wire wrBank = (wrWord == REG_BANK);
  wire wrMemAddr = (wrWord == REG_MEMADDR);
  wire wrMemData = (wrWord == REG_MEMDATA);
  wire wrReadOnly = (wrWord == REG_STATUS) || (wrWord == REG_LASTOP) ||
                    (wrWord == REG_RETIRED);
  assign wrHit = wrInstr || wrAcc || wrFlags || wrPc || wrBank || wrMemAddr ||
                 wrMemData || wrReadOnly;

  // Software writes land only while the sequencer is idle
  wire swWrite = wrEn && !busy;
  wire startExec = swWrite && wrInstr;
  wire [15:0] instrMerged = laneMerge(instr, wrData, wrStrb);
  wire [15:0] accMerged = laneMerge({8'h00, acc}, wrData, wrStrb);
  wire [15:0] flagsMerged = laneMerge({11'h000, flags}, wrData, wrStrb);
  wire [15:0] pcMerged = laneMerge(pc, wrData, wrStrb);
  wire [15:0] bankMerged = laneMerge({12'h000, bank}, wrData, wrStrb);
  wire [15:0] memAddrMerged = laneMerge({4'h0, memAddr}, wrData, wrStrb);
  wire swMemWe = swWrite && wrMemData && wrStrb[0];

  assign busy = (state != SEQ_IDLE);

  always_comb
  begin
    statusWord = 32'h0;
    statusWord[STAT_BUSY] = busy;
    statusWord[STAT_TAKEN] = lastTaken;
    statusWord[STAT_ILLEGAL] = illegal;
    statusWord[STAT_CYC +: 2] = lastCycles;
  end

  wire rdIsInstr = (rdWord == REG_INSTR);
  wire rdIsStatus = (rdWord == REG_STATUS);
  wire rdIsAcc = (rdWord == REG_ACC);
  wire rdIsFlags = (rdWord == REG_FLAGS);
  wire rdIsPc = (rdWord == REG_PC);
  wire rdIsBank = (rdWord == REG_BANK);
  wire rdIsMemAddr = (rdWord == REG_MEMADDR);
  wire rdIsMemData = (rdWord == REG_MEMDATA);
  wire rdIsLastOp = (rdWord == REG_LASTOP);
  wire rdIsRetired = (rdWord == REG_RETIRED);
  assign rdHit = rdIsInstr || rdIsStatus || rdIsAcc || rdIsFlags || rdIsPc || rdIsBank ||
                 rdIsMemAddr || rdIsMemData || rdIsLastOp || rdIsRetired;
  assign rdVal = rdIsInstr ? {16'h0000, instr} :
                 rdIsStatus ? statusWord :
                 rdIsAcc ? {24'h000000, acc} :
                 rdIsFlags ? {27'h0000000, flags} :
                 rdIsPc ? {16'h0000, pc} :
                 rdIsBank ? {28'h0000000, bank} :
                 rdIsMemAddr ? {20'h00000, memAddr} :
                 rdIsMemData ? {24'h000000, mem[memAddr]} :
                 rdIsLastOp ? {12'h000, dataAddr, aluRes} :
                 rdIsRetired ? {16'h0000, retiredCount} : 32'h0;

  // Four phases per instruction cycle; a taken branch adds a no-operation cycle
  always_comb
  begin
    next_state = state;
    next_phase = phase;
    unique case (state)
      SEQ_IDLE:
      begin
        if (startExec)
        begin
          next_state = SEQ_EXEC;
          next_phase = PH_Q1;
        end
      end
      SEQ_EXEC:
      begin
        next_phase = abbe_phase_t'(phase + 2'h1); // RL13
        if (phase == PH_Q4)
          next_state = brTaken ? SEQ_NOP : SEQ_IDLE; // RL11
      end
      SEQ_NOP:
      begin
        next_phase = abbe_phase_t'(phase + 2'h1);
        if (phase == PH_Q4)
          next_state = SEQ_IDLE; // RL11
      end
      default:
      begin
        next_state = SEQ_IDLE;
        next_phase = PH_Q1;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state <= SEQ_IDLE;
      phase <= PH_Q1;
    end
    else
    begin
      state <= next_state;
      phase <= next_phase;
    end
  end

  // Q1 decode: operation, destination, address and bit number
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      opKind <= OP_NONE;
      toReg <= 1'b0;
      dataAddr <= '0;
      bitSel <= 3'h0;
      illegal <= 1'b0;
    end
    else if (inQ1)
    begin
      opKind <= decOp; // RL13
      toReg <= isBclr || ((isAndReg || isAddc) && destSel); // RL4
      dataAddr <= effAddr; // RL5
      bitSel <= bitField; // RL6
      illegal <= (decOp == OP_NONE);
    end
  end

  // Q2 operand read, Q3 process and branch decision
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      operand <= 8'h00;
      aluRes <= 8'h00;
      aluFlags <= FLAGS_RST;
      brTaken <= 1'b0;
    end
    else if (inQ2)
      operand <= useLiteral ? fileAddr : mem[dataAddr]; // RL3 RL13
    else if (inQ3)
    begin
      aluRes <= aluResult; // RL13
      aluFlags <= aluFlagsOut;
      brTaken <= (opKind == OP_BRANCH) && condMet; // RL7 RL8
    end
  end

  // Q4 write-back of accumulator, flags and program counter
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      instr <= INSTR_RST;
      acc <= ACC_RST;
      flags <= FLAGS_RST;
      pc <= PC_RST;
      bank <= BANK_RST;
      memAddr <= '0;
    end
    else if (inQ4)
    begin
      if (writesAcc)
        acc <= aluRes; // RL1 RL4
      flags <= aluFlags; // RL2 RL6 RL8 RL12
      pc <= brTaken ? branchPc : seqPc; // RL10 RL11
    end
    else if (swWrite)
    begin
      if (wrInstr)
        instr <= instrMerged;
      if (wrAcc)
        acc <= accMerged[7:0];
      if (wrFlags)
        flags <= flagsMerged[4:0];
      if (wrPc)
        pc <= pcMerged;
      if (wrBank)
        bank <= bankMerged[3:0];
      if (wrMemAddr)
        memAddr <= memAddrMerged[MEM_AW-1:0];
    end
  end

  // Data memory; core write-back and software port never meet since software waits for idle
  always_ff @(posedge clk)
  begin
    if (coreMemWe)
      mem[dataAddr] <= aluRes; // RL4 RL6
    else if (swMemWe)
      mem[memAddr] <= wrData[7:0];
  end

  // Retirement bookkeeping
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      retire <= 1'b0;
      lastTaken <= 1'b0;
      lastCycles <= 2'h0;
      retiredCount <= 16'h0000;
    end
    else
    begin
      retire <= (inQ4 && !brTaken) || nopEnd;
      if (inQ4)
      begin
        lastTaken <= brTaken;
        lastCycles <= brTaken ? CYC_TWO : CYC_ONE; // RL11
      end
      if ((inQ4 && !brTaken) || nopEnd)
        retiredCount <= retiredCount + 16'h0001;
    end
  end

endmodule : abbe_core

`default_nettype wire

// ==== abbe_axil_host.sv ====
// AXI4-Lite master model standing in for the software side
`timescale 1ns/10ps
`default_nettype none
module abbe_axil_host
  import abbe_pkg::*;
(
  input wire logic clk,
  output logic awvalid,
  input wire logic awready,
  output logic [ADDR_W-1:0] awaddr,
  output logic wvalid,
  input wire logic wready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  input wire logic bvalid,
  output logic bready,
  input wire logic [1:0] bresp,
  output logic arvalid,
  input wire logic arready,
  output logic [ADDR_W-1:0] araddr,
  input wire logic rvalid,
  output logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp
);
  // Readies rise a cycle after each answer, so answers must hold
  initial
  begin
    {awvalid, wvalid, arvalid} = 3'h0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {bready, rready} = 2'h0;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      bready <= bvalid && !bready;
    end
    while (bvalid !== 1'b1 || bready !== 1'b1);
    r = bresp;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      rready <= rvalid && !rready;
    end
    while (rvalid !== 1'b1 || rready !== 1'b1);
    d = rdata;
    r = rresp;
  endtask : rd
endmodule : abbe_axil_host
`default_nettype wire

// ==== abbe_core_checker.sv ====
// Concurrent checks on the execution block's ports
`timescale 1ns/10ps
`default_nettype none
module abbe_core_checker
  import abbe_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic busy,
  input wire logic retire
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped early");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read response dropped early");
  a_arready_link: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("arready not the inverse of rvalid");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:4] s_axi_bvalid) else $error("write answer late");
  a_busy_min: assert property ($rose(busy) |-> busy[*4])
    else $error("instruction shorter than four phases");
  a_busy_max: assert property ($rose(busy) |-> ##[4:8] !busy)
    else $error("instruction longer than two cycles");
  a_retire_end: assert property ($fell(busy) |-> retire)
    else $error("no retire when busy falls");
  a_retire_once: assert property (retire |=> !retire)
    else $error("retire longer than one cycle");

  cover property (retire);
  cover property ($rose(busy) ##8 !busy);
  cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule : abbe_core_checker

bind abbe_core abbe_core_checker chk (.clk(clk), .rst_n(rst_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .busy(busy), .retire(retire));
`default_nettype wire

// ==== test_and_branch_bitclear_exec.sv ====
// Self-checking bench for the execution block
`timescale 1ns/10ps
`default_nettype none
module test_and_branch_bitclear_exec
  import abbe_pkg::*;
;
  logic clk, rst_n, busy, retire, awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
  logic [ADDR_W-1:0] awa, ara;
  logic [31:0] wd, rd;
  logic [3:0] ws;
  logic [1:0] bre, rre;
  int miscompares = 0, nChecks = 0, cyc = 0, runLen = 0;

  abbe_core dut (.clk(clk), .rst_n(rst_n), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd),
    .s_axi_wstrb(ws), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bre),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv),
    .s_axi_rready(rr), .s_axi_rdata(rd), .s_axi_rresp(rre), .busy(busy), .retire(retire));
  abbe_axil_host host (.clk(clk), .awvalid(awv), .awready(awr), .awaddr(awa),
    .wvalid(wv), .wready(wr), .wdata(wd), .wstrb(ws), .bvalid(bv), .bready(br),
    .bresp(bre), .arvalid(arv), .arready(arr), .araddr(ara), .rvalid(rv), .rready(rr),
    .rdata(rd), .rresp(rre));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Busy length of the current instruction, cleared by ex
  always @(posedge clk)
  begin
    cyc++;
    if (busy === 1'b1) runLen <= runLen + 1;
    if (cyc == 20000)
    begin
      miscompares++;
      print_verdict();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    nChecks++;
    if (g !== e)
    begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask : chk

  task automatic put(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    host.wr(a, d, r);
  endtask : put

  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    host.rd(a, d, r);
    chk(nm, e, d);
  endtask : rc

  task automatic mem(input logic [11:0] a, input logic [7:0] d);
    put(REG_MEMADDR, {20'h0, a});
    put(REG_MEMDATA, {24'h0, d});
  endtask : mem

  task automatic memChk(input logic [11:0] a, input logic [7:0] e);
    put(REG_MEMADDR, {20'h0, a});
    rc("mem", REG_MEMDATA, {24'h0, e});
  endtask : memChk

  task automatic ex(input logic [15:0] op, input int len);
    runLen = 0;
    put(REG_INSTR, {16'h0, op});
    for (int k = 0; k < 40 && retire !== 1'b1; k++) @(posedge clk);
    chk("busy cycles", len, runLen);
  endtask : ex

  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    rc("acc", REG_ACC, 32'h0);
    rc("flags", REG_FLAGS, 32'h0);
    rc("pc", REG_PC, 32'h0);
    host.rd(8'h40, d, r);
    chk("rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
    host.wr(8'h40, 32'h0, r);
    chk("bresp", {30'h0, RESP_SLVERR}, {30'h0, r});
    $display("test reset done");
  endtask : t_reset

  task automatic t_andlit();
    logic [7:0] av [3] = '{8'ha3, 8'h80, 8'h55};
    logic [7:0] kv [3] = '{8'h5f, 8'h80, 8'haa};
    logic [7:0] fv [3] = '{8'h0b, 8'h1b, 8'h0f};
    for (int i = 0; i < 3; i++)
    begin
      put(REG_ACC, {24'h0, av[i]});
      put(REG_FLAGS, 32'h0b);
      ex({OPC_ANDLIT, kv[i]}, 4);
      rc("acc", REG_ACC, {24'h0, av[i] & kv[i]});
      rc("flags", REG_FLAGS, {24'h0, fv[i]});
    end
    $display("test literal and done");
  endtask : t_andlit

  task automatic t_andreg();
    for (int i = 0; i < 4; i++)
    begin
      logic [11:0] hit, miss;
      hit = i[0] ? 12'h290 : 12'hf90;
      miss = i[0] ? 12'hf90 : 12'h290;
      mem(miss, 8'h0f);
      mem(hit, 8'hc2);
      put(REG_ACC, 32'h17);
      put(REG_BANK, 32'h2);
      put(REG_FLAGS, 32'h1f);
      ex({OPC_ANDREG, i[1], i[0], 8'h90}, 4);
      rc("acc", REG_ACC, i[1] ? 32'h17 : 32'h02);
      memChk(hit, i[1] ? 8'h02 : 8'hc2);
      rc("flags", REG_FLAGS, 32'h0b);
    end
    $display("test register and done");
  endtask : t_andreg

  task automatic t_bclr();
    for (int b = 0; b < 8; b++)
    begin
      mem(12'h010, 8'hff);
      put(REG_FLAGS, 32'h1f);
      ex({OPC_BCLR, 3'(b), 1'b0, 8'h10}, 4);
      memChk(12'h010, ~(8'h01 << b));
      rc("flags", REG_FLAGS, 32'h1f);
    end
    $display("test bit clear done");
  endtask : t_bclr

  task automatic t_addc();
    mem(12'h010, 8'h02);
    put(REG_ACC, 32'h4d);
    put(REG_FLAGS, 32'h01);
    ex({OPC_ADDC, 2'b00, 8'h10}, 4);
    rc("acc", REG_ACC, 32'h50);
    rc("flags", REG_FLAGS, 32'h02);
    $display("test add with carry done");
  endtask : t_addc

  task automatic t_branch();
    logic [15:0] ops [6] = '{16'he205, 16'he205, 16'he680, 16'he67f, 16'he67f, 16'h0000};
    logic [4:0] fl [6] = '{5'h01, 5'h10, 5'h10, 5'h01, 5'h1f, 5'h00};
    for (int i = 0; i < 6; i++)
    begin
      logic tk;
      logic [15:0] pcx;
      logic [31:0] d;
      logic [1:0] r;
      tk = ops[i][10] ? fl[i][FLG_N] : fl[i][FLG_C];
      pcx = 16'h0102 + (tk ? {{7{ops[i][7]}}, ops[i][7:0], 1'b0} : 16'h0);
      put(REG_PC, 32'h0100);
      put(REG_FLAGS, {27'h0, fl[i]});
      ex(ops[i], tk ? 8 : 4);
      rc("pc", REG_PC, {16'h0, pcx});
      rc("flags", REG_FLAGS, {27'h0, fl[i]});
      host.rd(REG_STATUS, d, r);
      chk("status", {27'h0, tk ? 2'h2 : 2'h1, 1'b0, ops[i] == 0, tk}, {27'h0, d[5:1]});
    end
    $display("test branches done");
  endtask : t_branch

  task automatic print_verdict();
    $display("checks %0d miscompares %0d", nChecks, miscompares);
    if (miscompares == 0 && nChecks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  initial
  begin
    rst_n = 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_andlit();
    t_andreg();
    t_bclr();
    t_addc();
    t_branch();
    print_verdict();
  end
endmodule : test_and_branch_bitclear_exec
`default_nettype wire
